// [logic/cwcs_pkg.sv]
// Package for the configuration word decoder: addresses, bit positions, reset values and codes.
// Assumes a single 50 MHz clock domain and a plain strobe register port.
package cwcs_pkg;
  // Program-space locations of the two configuration words.
  localparam logic [13:0] CWCS_ADDR_CFG1 = 14'h2007;
  localparam logic [13:0] CWCS_ADDR_CFG2 = 14'h2008;
  // Register port offsets for the oscillator registers, chosen locally.
  localparam logic [13:0] CWCS_ADDR_OSC_CTRL = 14'h0000;
  localparam logic [13:0] CWCS_ADDR_OSC_TRIM = 14'h0001;
  localparam logic [13:0] CWCS_ADDR_STATUS = 14'h0002;
  // Configuration word one bit positions.
  localparam int CWCS_B_DEBUG = 13;
  localparam int CWCS_B_FAST = 12;
  localparam int CWCS_B_UNIMP_HI = 11;
  localparam int CWCS_B_BOR_LVL = 10;
  localparam int CWCS_B_BOR_HI = 9;
  localparam int CWCS_B_BOR_LO = 8;
  localparam int CWCS_B_UNIMP_LO = 7;
  localparam int CWCS_B_PROT_N = 6;
  localparam int CWCS_B_MRSEL = 5;
  localparam int CWCS_B_PUT_N = 4;
  localparam int CWCS_B_WDT = 3;
  // Erased word value and the mask of bits forced to one on readback.
  localparam logic [13:0] CWCS_CFG_ERASED = 14'h3fff;
  localparam logic [13:0] CWCS_CFG_UNIMP_MASK = 14'h0880;
  localparam logic [13:0] CWCS_CFG2_ERASED = 14'h3fff;
  // Oscillator control fields.
  localparam int CWCS_B_IFS_LO = 4;
  localparam int CWCS_B_LOCKED = 3;
  localparam int CWCS_B_STABLE = 2;
  localparam logic [1:0] CWCS_IFS_RESET = 2'h2;
  localparam logic [5:0] CWCS_TRIM_RESET = 6'h00;
  // Clock output divider ratio.
  localparam int CWCS_CLK_OUT_DIV = 4;
  // Clock source codes.
  typedef enum logic [2:0] {
    CWCS_OSC_LP = 3'h0, CWCS_OSC_XT = 3'h1, CWCS_OSC_HS = 3'h2, CWCS_OSC_EC = 3'h3,
    CWCS_OSC_INT_IO = 3'h4, CWCS_OSC_INT_CLK = 3'h5, CWCS_OSC_RC_IO = 3'h6,
    CWCS_OSC_RC_CLK = 3'h7
  } cwcs_osc_e;
  // Brown-out modes.
  typedef enum logic [1:0] {
    CWCS_BOR_OFF = 2'h0, CWCS_BOR_RUN = 2'h2, CWCS_BOR_ON = 2'h3
  } cwcs_bor_e;
  // Frequency width in kHz units; the divider module does not use it.
  localparam int CWCS_FREQ_KHZ_W = 16;
  // Decode a two-bit frequency select into a frequency in units of 62.5 kHz.
  function automatic logic [8:0] cwcs_freq_units(input logic fast, input logic [1:0] sel);
    logic [8:0] base;
    base = fast ? 9'h020 : 9'h001;
    cwcs_freq_units = base << sel;
  endfunction
endpackage

// [logic/cwcs_cfg_if.sv]
// Carries the decoded configuration from the decoder core to the top.
// Assumes both ends sit in the mclk domain.
interface cwcs_cfg_if;
  logic debug_owns_pins;
  logic fast_internal_clock_select;
  logic bor_low_threshold;
  logic [1:0] bor_mode;
  logic protect;
  logic reset_pin_is_reset;
  logic powerup_timer_on;
  logic watchdog_on;
  logic [2:0] osc_mode;
  modport src (output debug_owns_pins, fast_internal_clock_select, bor_low_threshold,
    bor_mode, protect, reset_pin_is_reset, powerup_timer_on, watchdog_on, osc_mode);
  modport dst (input debug_owns_pins, fast_internal_clock_select, bor_low_threshold,
    bor_mode, protect, reset_pin_is_reset, powerup_timer_on, watchdog_on, osc_mode);
endinterface

// [logic/cwcs_clkdiv.sv]
// Divide-by-four clock output generator driven by one-cycle oscillator tick enables.
// Assumes the tick input is a single-cycle pulse in the mclk domain.
module cwcs_clkdiv (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Oscillator tick and enable.
  input wire logic osc_tick,
  input wire logic run,
  // Divided output.
  output logic clk_out
);
  typedef struct packed {
    logic [0:0] half;
    logic out;
  } cwcs_div_s;
  cwcs_div_s s_q, s_d;

  // Toggle the output every two ticks so that four ticks make one period.
  always_comb begin
    s_d = s_q;
    if (!run) begin
      s_d = '0;
    end else if (osc_tick) begin
      s_d.half = ~s_q.half;
      if (s_q.half == 1'b1) begin
        s_d.out = ~s_q.out;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_out = s_q.out;
endmodule

// [logic/cwcs_top.sv]
// Configuration word decoder with oscillator control and trim registers.
// Assumes mclk at 50 MHz, synchronous pin inputs and an external programmer port.
//
// Decided for this implementation: the address-and-strobe port.
module cwcs_top (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Programmer port.
  input wire logic prog_mode,
  input wire logic [13:0] addr,
  input wire logic [13:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [13:0] rdata,
  // Erase request towards the program memory.
  output logic erase_all,
  // Oscillator ticks and status from the analog side.
  input wire logic rc_osc_tick,
  input wire logic int_osc_tick,
  input wire logic int_osc_locked,
  input wire logic int_osc_stable,
  // Master reset and general purpose pin inputs.
  input wire logic master_reset_pin,
  input wire logic osc_output_gpio_out,
  input wire logic osc_output_gpio_oe,
  // Oscillator output pin.
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe,
  output logic osc_output_is_gpio,
  output logic osc_input_is_gpio,
  // Decoded static controls.
  output logic debug_owns_pins,
  output logic fast_internal_clock_select,
  output logic bor_low_threshold,
  output logic bor_enable_run,
  output logic bor_enable_sleep,
  output logic code_protect_active,
  output logic reset_pin_is_reset,
  output logic reset_pin_is_input,
  output logic internal_reset,
  output logic powerup_timer_on,
  output logic watchdog_on,
  output logic [2:0] osc_mode,
  output logic internal_osc_run,
  output logic [1:0] internal_freq_select,
  output logic [5:0] freq_trim,
  output logic [8:0] int_freq_units
);
  typedef struct packed {
    logic [13:0] cfg1;
    logic [13:0] cfg2;
    logic loaded;
    logic [13:0] live1;
    logic [1:0] ifs;
    logic [5:0] trim;
    logic [13:0] rdata;
    logic erase;
  } cwcs_state_s;
  // The stored words power up erased; only a programmer write changes them afterwards.
  cwcs_state_s s_q = '{cfg1: cwcs_pkg::CWCS_CFG_ERASED, cfg2: cwcs_pkg::CWCS_CFG2_ERASED,
    default: '0};
  cwcs_state_s s_d;
  cwcs_cfg_if cfg ();
  logic rc_mode, int_mode, osc_run;
  logic rc_clk, int_clk;

  // Decode of the configuration word that was latched after reset.
  // held after reset
  assign cfg.debug_owns_pins = ~s_q.live1[cwcs_pkg::CWCS_B_DEBUG];
  assign cfg.fast_internal_clock_select = s_q.live1[cwcs_pkg::CWCS_B_FAST];
  assign cfg.bor_low_threshold = s_q.live1[cwcs_pkg::CWCS_B_BOR_LVL];
  assign cfg.bor_mode = s_q.live1[cwcs_pkg::CWCS_B_BOR_HI:cwcs_pkg::CWCS_B_BOR_LO];
  assign cfg.protect = ~s_q.live1[cwcs_pkg::CWCS_B_PROT_N];
  assign cfg.reset_pin_is_reset = s_q.live1[cwcs_pkg::CWCS_B_MRSEL];
  assign cfg.powerup_timer_on = ~s_q.live1[cwcs_pkg::CWCS_B_PUT_N];
  assign cfg.watchdog_on = s_q.live1[cwcs_pkg::CWCS_B_WDT];
  assign cfg.osc_mode = s_q.live1[2:0];

  // Register file, configuration programming and the one-shot capture at reset release.
  always_comb begin
    s_d = s_q;
    s_d.erase = 1'b0;
    s_d.rdata = '0;
    if (!s_q.loaded) begin
      s_d.loaded = 1'b1;
      s_d.live1 = s_q.cfg1;
    end
    if (wr_stb) begin
      if (prog_mode && addr == cwcs_pkg::CWCS_ADDR_CFG1) begin
        s_d.cfg1 = wdata | cwcs_pkg::CWCS_CFG_UNIMP_MASK;
        if (!s_q.cfg1[cwcs_pkg::CWCS_B_PROT_N] && wdata[cwcs_pkg::CWCS_B_PROT_N]) begin
          s_d.erase = 1'b1;
        end
      end else if (prog_mode && addr == cwcs_pkg::CWCS_ADDR_CFG2) begin
        s_d.cfg2 = wdata;
      end else if (!prog_mode && addr == cwcs_pkg::CWCS_ADDR_OSC_CTRL) begin
        s_d.ifs = wdata[cwcs_pkg::CWCS_B_IFS_LO +: 2];
      end else if (!prog_mode && addr == cwcs_pkg::CWCS_ADDR_OSC_TRIM) begin
        s_d.trim = wdata[5:0];
      end
    end
    if (rd_stb) begin
      if (prog_mode && addr == cwcs_pkg::CWCS_ADDR_CFG1) begin
        s_d.rdata = s_q.cfg1 | cwcs_pkg::CWCS_CFG_UNIMP_MASK;
      end else if (prog_mode && addr == cwcs_pkg::CWCS_ADDR_CFG2) begin
        s_d.rdata = s_q.cfg2;
      end else if (!prog_mode && addr == cwcs_pkg::CWCS_ADDR_OSC_CTRL) begin
        s_d.rdata[cwcs_pkg::CWCS_B_IFS_LO +: 2] = s_q.ifs;
        s_d.rdata[cwcs_pkg::CWCS_B_LOCKED] = int_osc_locked;
        s_d.rdata[cwcs_pkg::CWCS_B_STABLE] = int_osc_stable;
      end else if (!prog_mode && addr == cwcs_pkg::CWCS_ADDR_OSC_TRIM) begin
        s_d.rdata[5:0] = s_q.trim;
      end else if (!prog_mode && addr == cwcs_pkg::CWCS_ADDR_STATUS) begin
        s_d.rdata = s_q.live1;
      end
    end
  end

  // Reset loads the volatile fields with their reset values only; the stored words survive it, as flash would.
  // The live copy shows the erased word during reset and reloads one edge after release.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q.loaded <= 1'b0;
      s_q.live1 <= cwcs_pkg::CWCS_CFG_ERASED;
      s_q.ifs <= cwcs_pkg::CWCS_IFS_RESET;
      s_q.trim <= cwcs_pkg::CWCS_TRIM_RESET;
      s_q.rdata <= '0;
      s_q.erase <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Clock source decode.
  // clock source decode
  assign rc_mode = cfg.osc_mode == cwcs_pkg::CWCS_OSC_RC_CLK ||
    cfg.osc_mode == cwcs_pkg::CWCS_OSC_RC_IO;
  assign int_mode = cfg.osc_mode == cwcs_pkg::CWCS_OSC_INT_CLK ||
    cfg.osc_mode == cwcs_pkg::CWCS_OSC_INT_IO;
  assign osc_run = !(cfg.reset_pin_is_reset && master_reset_pin && (rc_mode || int_mode));

  cwcs_clkdiv u_rc_div (
    .mclk(mclk),
    .rst(rst),
    .osc_tick(rc_osc_tick),
    .run(osc_run),
    .clk_out(rc_clk)
  );

  cwcs_clkdiv u_int_div (
    .mclk(mclk),
    .rst(rst),
    .osc_tick(int_osc_tick),
    .run(osc_run),
    .clk_out(int_clk)
  );

  // Oscillator pins follow the clock source mode.
  always_comb begin
    osc_output_is_gpio = 1'b0;
    osc_input_is_gpio = 1'b0;
    osc_output_pin_o = 1'b0;
    osc_output_pin_oe = 1'b0;
    case (cfg.osc_mode)
      cwcs_pkg::CWCS_OSC_RC_CLK: begin
        osc_output_pin_o = rc_clk;
        osc_output_pin_oe = 1'b1;
      end
      cwcs_pkg::CWCS_OSC_RC_IO, cwcs_pkg::CWCS_OSC_EC: begin
        osc_output_is_gpio = 1'b1;
        osc_output_pin_o = osc_output_gpio_out;
        osc_output_pin_oe = osc_output_gpio_oe;
      end
      cwcs_pkg::CWCS_OSC_INT_CLK: begin
        osc_input_is_gpio = 1'b1;
        osc_output_pin_o = int_clk;
        osc_output_pin_oe = 1'b1;
      end
      cwcs_pkg::CWCS_OSC_INT_IO: begin
        osc_input_is_gpio = 1'b1;
        osc_output_is_gpio = 1'b1;
        osc_output_pin_o = osc_output_gpio_out;
        osc_output_pin_oe = osc_output_gpio_oe;
      end
      default: begin
        osc_output_pin_oe = 1'b0;
      end
    endcase
  end

  // Static control outputs.
  // debugger pin ownership
  assign debug_owns_pins = cfg.debug_owns_pins;
  assign fast_internal_clock_select = cfg.fast_internal_clock_select;
  assign bor_low_threshold = cfg.bor_low_threshold;
  assign bor_enable_run = cfg.bor_mode[1];
  assign bor_enable_sleep = cfg.bor_mode == cwcs_pkg::CWCS_BOR_ON;
  assign code_protect_active = cfg.protect;
  assign reset_pin_is_reset = cfg.reset_pin_is_reset;
  assign reset_pin_is_input = ~cfg.reset_pin_is_reset;
  assign internal_reset = cfg.reset_pin_is_reset & master_reset_pin;
  assign powerup_timer_on = cfg.powerup_timer_on;
  assign watchdog_on = cfg.watchdog_on;
  assign osc_mode = cfg.osc_mode;
  assign internal_osc_run = osc_run & int_mode;
  assign internal_freq_select = s_q.ifs;
  assign freq_trim = s_q.trim;
  assign int_freq_units = cwcs_pkg::cwcs_freq_units(cfg.fast_internal_clock_select, s_q.ifs);
  assign rdata = s_q.rdata;
  assign erase_all = s_q.erase;

  property p_erase_on_unprotect;
    @(posedge mclk) disable iff (rst)
      (wr_stb && prog_mode && addr == cwcs_pkg::CWCS_ADDR_CFG1 &&
       !s_q.cfg1[cwcs_pkg::CWCS_B_PROT_N] && wdata[cwcs_pkg::CWCS_B_PROT_N]) |=> erase_all;
  endproperty
  a_erase_on_unprotect: assert property (p_erase_on_unprotect) else $error("no erase");

  property p_live_static;
    @(posedge mclk) disable iff (rst)
      s_q.loaded |=> $stable(s_q.live1);
  endproperty
  a_live_static: assert property (p_live_static) else $error("config changed");

  property p_unimp_one;
    @(posedge mclk) disable iff (rst)
      (rd_stb && prog_mode && addr == cwcs_pkg::CWCS_ADDR_CFG1) |=>
        rdata[11] && rdata[7];
  endproperty
  a_unimp_one: assert property (p_unimp_one) else $error("unimplemented bit zero");

  property p_no_cfg_read_run;
    @(posedge mclk) disable iff (rst)
      (rd_stb && !prog_mode && addr == cwcs_pkg::CWCS_ADDR_CFG1) |=> rdata == 14'h0000;
  endproperty
  a_no_cfg_read_run: assert property (p_no_cfg_read_run) else $error("config read");

  property p_osc_held;
    @(posedge mclk) disable iff (rst)
      (reset_pin_is_reset && master_reset_pin && int_mode) |-> !internal_osc_run;
  endproperty
  a_osc_held: assert property (p_osc_held) else $error("oscillator running");

  property p_rc_io;
    @(posedge mclk) disable iff (rst)
      osc_mode == cwcs_pkg::CWCS_OSC_RC_IO |-> osc_output_is_gpio;
  endproperty
  a_rc_io: assert property (p_rc_io) else $error("RC I/O pin not free");

  property p_rc_clk;
    @(posedge mclk) disable iff (rst)
      (osc_mode == cwcs_pkg::CWCS_OSC_RC_CLK && osc_run) |->
        osc_output_pin_oe && osc_output_pin_o == rc_clk;
  endproperty
  a_rc_clk: assert property (p_rc_clk) else $error("RC clock out wrong");

  property p_ifs_write;
    @(posedge mclk) disable iff (rst)
      (wr_stb && !prog_mode && addr == cwcs_pkg::CWCS_ADDR_OSC_CTRL) |=>
        internal_freq_select == $past(wdata[5:4]);
  endproperty
  a_ifs_write: assert property (p_ifs_write) else $error("select not stored");

  // Raw timer bit of the live word, for the polarity check below.
  logic status_put_bit;
  assign status_put_bit = s_q.live1[cwcs_pkg::CWCS_B_PUT_N];
  property p_put_n;
    @(posedge mclk) disable iff (rst)
      powerup_timer_on == !status_put_bit;
  endproperty
  a_put_n: assert property (p_put_n) else $error("timer polarity");
endmodule

// [tb/cwcs_programmer.sv]
// Behavioural model of the external programmer that owns the register port.
// Assumes one mclk domain; each task starts at the next rising edge and ends on one.
module cwcs_programmer (
  // Clock.
  input wire logic mclk,
  // Register port drive.
  output logic prog_mode,
  output logic [13:0] addr,
  output logic [13:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] exp_q[$];
  logic rd_pend;

  // Idle port at time zero, so the device never sees a floating strobe.
  initial begin
    {prog_mode, wr_stb, rd_stb} = 3'h0;
    {addr, wdata} = 28'h0000000;
  end

  // A write is one strobe cycle; data and address are held until the sampling edge.
  task automatic wr(input logic [13:0] a, input logic [13:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // A read notes its expected word; the answer stands in the following cycle only.
  task automatic rd(input logic [13:0] a, input logic [13:0] e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd_stb <= 1'b0;
  endtask

  task automatic set_mode(input logic m);
    @(posedge mclk);
    prog_mode <= m;
  endtask

  // Marks the cycle in which read data must stand.
  always @(posedge mclk) begin
    rd_pend <= rd_stb;
  end
endmodule

// [tb/config_word_clock_select_bench.sv]
// Self-checking bench for the configuration word decoder and its oscillator registers.
// Assumes the programmer model drives the register port and this module drives the pins.
module config_word_clock_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, prog_mode, wr_stb, rd_stb, erase_all;
  logic [13:0] addr, wdata, rdata;
  logic rc_osc_tick, int_osc_tick, int_osc_locked, int_osc_stable, master_reset_pin;
  logic osc_output_gpio_out, osc_output_gpio_oe, osc_output_pin_o, osc_output_pin_oe;
  logic osc_output_is_gpio, osc_input_is_gpio, debug_owns_pins, fast_internal_clock_select;
  logic bor_low_threshold, bor_enable_run, bor_enable_sleep, code_protect_active;
  logic reset_pin_is_reset, reset_pin_is_input, internal_reset, powerup_timer_on;
  logic watchdog_on, internal_osc_run;
  logic [2:0] osc_mode;
  logic [1:0] internal_freq_select;
  logic [5:0] freq_trim;
  logic [8:0] int_freq_units;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rnd = 32'h000121e5;
  localparam logic [13:0] a_cfg1 = cwcs_pkg::CWCS_ADDR_CFG1;
  localparam logic [13:0] a_ctl = cwcs_pkg::CWCS_ADDR_OSC_CTRL;
  localparam logic [13:0] a_trim = cwcs_pkg::CWCS_ADDR_OSC_TRIM;
  localparam logic [13:0] unimp = cwcs_pkg::CWCS_CFG_UNIMP_MASK;

  // Device and the programmer that owns its register port.
  cwcs_top i_cwcs_top (.mclk, .rst, .prog_mode, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .erase_all, .rc_osc_tick, .int_osc_tick, .int_osc_locked, .int_osc_stable,
    .master_reset_pin, .osc_output_gpio_out, .osc_output_gpio_oe, .osc_output_pin_o,
    .osc_output_pin_oe, .osc_output_is_gpio, .osc_input_is_gpio, .debug_owns_pins,
    .fast_internal_clock_select, .bor_low_threshold, .bor_enable_run, .bor_enable_sleep,
    .code_protect_active, .reset_pin_is_reset, .reset_pin_is_input, .internal_reset,
    .powerup_timer_on, .watchdog_on, .osc_mode, .internal_osc_run, .internal_freq_select,
    .freq_trim, .int_freq_units);
  cwcs_programmer i_cwcs_programmer (.mclk, .prog_mode, .addr, .wdata, .wr_stb, .rd_stb);

  // Free-running 50 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Unequal tick periods, so a swapped oscillator source shows up as a wrong rate.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rc_osc_tick <= (cyc % 2) == 0;
    int_osc_tick <= (cyc % 3) == 0;
  end

  // Read data stand for one cycle only, so they are taken at that cycle's falling edge.
  always @(negedge mclk) begin
    if (i_cwcs_programmer.rd_pend === 1'b1) begin
      chk(rdata, i_cwcs_programmer.exp_q.pop_front(), "read");
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({13'h0000, got}, {13'h0000, exp}, "flag");
  endtask

  task automatic test_done;
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Short names for the programmer's bus tasks.
  task automatic p_wr(input logic [13:0] a, input logic [13:0] d);
    i_cwcs_programmer.wr(a, d);
  endtask
  task automatic p_rd(input logic [13:0] a, input logic [13:0] e);
    i_cwcs_programmer.rd(a, e);
  endtask
  task automatic p_mode(input logic m);
    i_cwcs_programmer.set_mode(m);
  endtask

  // Eight cycles of reset, then two quiet edges before the first request.
  task automatic do_reset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // Compares every decoded control with the bits of the word loaded at reset.
  task automatic chk_dec(input logic [13:0] w, input logic mr);
    @(negedge mclk);
    chk1(debug_owns_pins, ~w[13]);
    chk1(fast_internal_clock_select, w[12]);
    chk1(bor_low_threshold, w[10]);
    chk1(bor_enable_run, w[9]);
    chk1(bor_enable_sleep, w[9] & w[8]);
    chk1(code_protect_active, ~w[6]);
    chk1(reset_pin_is_reset, w[5]);
    chk1(reset_pin_is_input, ~w[5]);
    chk1(internal_reset, w[5] & mr);
    chk1(powerup_timer_on, ~w[4]);
    chk1(watchdog_on, w[3]);
    chk({11'h000, osc_mode}, {11'h000, w[2:0]}, "mode");
    chk1(osc_output_is_gpio, w[2:0] inside {3'h3, 3'h4, 3'h6});
    chk1(osc_input_is_gpio, w[2:0] inside {3'h4, 3'h5});
    if (w[5] & mr & w[2]) begin
      chk1(internal_osc_run, 1'b0);
    end else begin
      chk1(internal_osc_run, w[2:0] inside {3'h4, 3'h5});
    end
  endtask

  // Measures one period of the clock output pin in mclk cycles, with a bound on the wait.
  task automatic meas(input int exp);
    int n, t0;
    n = 0;
    t0 = 0;
    for (int k = 0; k < 4; k++) begin
      while (osc_output_pin_o !== k[0] && n < 60) begin
        @(negedge mclk);
        n++;
      end
      if (k == 1) begin
        t0 = n;
      end
    end
    if (n >= 60) begin
      fail_count++;
      $display("Error at %0t: clock output stuck", $time);
      test_done();
    end
    chk(14'(n - t0), 14'(exp), "period");
    chk1(osc_output_pin_oe, 1'b1);
  endtask

  // Main sequence: random words through every clock mode, then erase and pin checks.
  initial begin
    logic [13:0] w;
    logic mr;
    logic [1:0] sel;
    {rst, rc_osc_tick, int_osc_tick, int_osc_locked, int_osc_stable} = 5'h10;
    {master_reset_pin, osc_output_gpio_out, osc_output_gpio_oe} = 3'h0;
    do_reset();
    p_mode(1'b1);
    p_rd(a_cfg1, cwcs_pkg::CWCS_CFG_ERASED);
    p_rd(cwcs_pkg::CWCS_ADDR_CFG2, cwcs_pkg::CWCS_CFG2_ERASED);
    p_rd(a_ctl, 14'h0000);
    p_rd(14'h0100, 14'h0000);
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      w = rnd[13:0];
      if (i < 8) begin
        w[2:0] = i[2:0];
        w[12] = i[0];
      end
      w[5] = w[5] | (i == 5) | (i == 7);
      mr = rnd[20] | (i == 5) | (i == 7);
      sel = i[2:1];
      @(posedge mclk);
      master_reset_pin <= mr;
      int_osc_locked <= rnd[21];
      int_osc_stable <= rnd[22];
      p_mode(1'b1);
      p_wr(a_cfg1, w);
      p_rd(a_cfg1, w | unimp);
      p_mode(1'b0);
      p_rd(a_cfg1, 14'h0000);
      p_wr(a_cfg1, 14'h0000);
      do_reset();
      chk_dec(w, mr);
      @(posedge mclk);
      master_reset_pin <= 1'b0;
      p_rd(cwcs_pkg::CWCS_ADDR_STATUS, w | unimp);
      p_rd(a_ctl, {8'h00, 2'h2, rnd[21], rnd[22], 2'h0});
      p_rd(a_trim, 14'h0000);
      p_wr(a_ctl, {8'h00, sel, 4'h0});
      p_wr(a_trim, {8'h00, rnd[28:23]});
      p_rd(a_ctl, {8'h00, sel, rnd[21], rnd[22], 2'h0});
      p_rd(a_trim, {8'h00, rnd[28:23]});
      @(negedge mclk);
      chk({12'h000, internal_freq_select}, {12'h000, sel}, "select");
      chk({5'h00, int_freq_units}, {5'h00, (w[12] ? 9'h020 : 9'h001) << sel}, "freq");
      chk({8'h00, freq_trim}, {8'h00, rnd[28:23]}, "trim");
      p_mode(1'b1);
      p_wr(a_cfg1, ~w);
      p_mode(1'b0);
      chk_dec(w, 1'b0);
    end
    // Switching protection on must not erase; switching it off must pulse once.
    p_mode(1'b1);
    p_wr(a_cfg1, 14'h3fbf);
    @(negedge mclk);
    chk1(erase_all, 1'b0);
    p_wr(a_cfg1, 14'h3fff);
    @(negedge mclk);
    chk1(erase_all, 1'b1);
    @(negedge mclk);
    chk1(erase_all, 1'b0);
    p_mode(1'b0);
    do_reset();
    meas(8);
    p_mode(1'b1);
    p_wr(a_cfg1, 14'h3ffd);
    p_mode(1'b0);
    do_reset();
    meas(12);
    p_mode(1'b1);
    p_wr(a_cfg1, 14'h3ffe);
    p_mode(1'b0);
    do_reset();
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      osc_output_gpio_out <= k[0];
      osc_output_gpio_oe <= k[1];
      @(negedge mclk);
      chk1(osc_output_pin_o, k[0]);
      chk1(osc_output_pin_oe, k[1]);
    end
    test_done();
  end
endmodule
